/* core/pmd_pkg.sv */
/*
 * Package for the peripheral module disable block: register offset, bit
 * positions, reset value and the carrier types shared by the design.
 * Assumes a single 40 MHz system clock and a synchronous active-low reset.
 */
// Operation
// - Every disable bit is clear after any reset; all modules start enabled.
// - A set disable bit stops clock enable and control inputs to that module.
// - Writes to a disabled module's registers are dropped.
// - A disabled module is held in reset and its register reads return zero.
// - Clearing a bit returns the module in its reset state.
// - A re-enabled module may need up to one instruction cycle to become active.
// - Disabling a module also disables its pin-routing select registers.
// - System-clock gate bit blocks peripheral system clock; other peripherals unaffected.
// - Bit 1 set disables clock reference output; clear leaves it enabled.
package pmd_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W                  = 8;
    localparam int          DATA_W                  = 8;
    localparam logic [7:0]  PERIPHERAL_DISABLE_CONTROL_ZERO_OFS = 8'h00;
    localparam logic [7:0]  PERIPHERAL_DISABLE_CONTROL_ZERO_RST = 8'h00;
    localparam logic [7:0]  PERIPHERAL_DISABLE_CONTROL_ZERO_MSK = 8'hC7;

    // ----------------------------------------------------------------
    // Bit positions
    // ----------------------------------------------------------------
    localparam int          SYSTEM_CLOCK_GATE_BIT      = 7;
    localparam int          VOLTAGE_REFERENCE_OFF_BIT  = 6;
    localparam int          NONVOLATILE_ACCESS_OFF_BIT = 2;
    localparam int          CLOCK_REFERENCE_OFF_BIT    = 1;
    localparam int          PIN_CHANGE_DETECT_OFF_BIT  = 0;

    // ----------------------------------------------------------------
    // Module indices and timing
    // ----------------------------------------------------------------
    localparam int          NUM_MODULES   = 5;
    localparam int          MOD_PERIPHERAL_SYSTEM_CLOCK    = 0;
    localparam int          MOD_VREF      = 1;
    localparam int          MOD_NVM       = 2;
    localparam int          MOD_CLKREF    = 3;
    localparam int          MOD_PINCHG    = 4;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          INSTR_CYCLE_NS = 100;
    localparam int          WAKE_CYCLES   = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register-port request toward this block
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_type;

    // Per-module gating controls
    typedef struct packed {
        logic [NUM_MODULES-1:0] clk_en;
        logic [NUM_MODULES-1:0] hold_rst;
        logic [NUM_MODULES-1:0] active;
    } gate_type;

endpackage : pmd_pkg

/* core/pmd_wake.sv */
/*
 * Per-module wake delay: after a module is re-enabled, its active flag
 * rises only after a fixed count of clocks, modelling the settling time.
 * Assumes the disable level is synchronous to clk_i.
 */
`timescale 1ns/1ps
module pmd_wake #(
    parameter int CYCLES = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic disable_i,
    output logic      active_o
);
    import pmd_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);

    // Elaboration check: a zero count would let a unit wake with no settling
    if (CYCLES < 1) begin : g_bad_cycles
        $error("pmd_wake: CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    // ----------------------------------------------------------------
    // Settling counter
    // ----------------------------------------------------------------
    // Counter restarts on every disable so a short enable pulse cannot wake early
    always_comb begin
        nxt_cnt = cnt_ff;
        if (disable_i) begin
            nxt_cnt = '0;
        end else if (cnt_ff != CW'(CYCLES)) begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Active only once the full settling count has passed
    assign active_o = !disable_i && (cnt_ff == CW'(CYCLES));

    wake_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(disable_i) |-> !active_o [*4]) else $error("woke too early");

endmodule : pmd_wake

/* core/peripheral_module_disable.sv */
/*
 * Peripheral module disable control: one software register whose bits cut
 * clock enables, hold resets and fence the register and pin-routing access of
 * five peripheral groups. Assumes a plain register port, one clock, and that
 * the peripherals' own register ports pass through this block.
 */
`timescale 1ns/1ps
module peripheral_module_disable #(
    parameter int WAKE = pmd_pkg::WAKE_CYCLES
) (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_n_i,
    // Register port for the control register
    input  wire logic [pmd_pkg::ADDR_W-1:0]             addr_i,
    input  wire logic [pmd_pkg::DATA_W-1:0]             wdata_i,
    input  wire logic                                   wr_i,
    input  wire logic                                   rd_i,
    output logic      [pmd_pkg::DATA_W-1:0]             rdata_o,
    // Peripheral register access pass-through, one strobe per module
    input  wire logic [pmd_pkg::NUM_MODULES-1:0]        per_wr_i,
    input  wire logic [pmd_pkg::NUM_MODULES-1:0]        per_rd_i,
    input  wire logic [pmd_pkg::NUM_MODULES*8-1:0]      per_rdata_i,
    output logic      [pmd_pkg::NUM_MODULES-1:0]        per_wr_o,
    output logic      [pmd_pkg::NUM_MODULES*8-1:0]      per_rdata_o,
    // Pin-routing select register write strobes per module
    input  wire logic [pmd_pkg::NUM_MODULES-1:0]        route_wr_i,
    output logic      [pmd_pkg::NUM_MODULES-1:0]        route_wr_o,
    output logic      [pmd_pkg::NUM_MODULES-1:0]        route_en_o,
    // Gating toward the peripherals
    output logic      [pmd_pkg::NUM_MODULES-1:0]        clk_en_o,
    output logic      [pmd_pkg::NUM_MODULES-1:0]        hold_rst_o,
    output logic      [pmd_pkg::NUM_MODULES-1:0]        active_o,
    output logic                                        peripheral_system_clock_gate_o
);
    import pmd_pkg::*;

    // Elaboration check: a zero wake count would skip the settling time
    if (WAKE < 1) begin : g_bad_wake
        $error("WAKE must be at least 1");
    end

    // Mask of writable bits, also the read mask
    function automatic logic [7:0] legal_bits(input logic [7:0] v);
        legal_bits = v & PERIPHERAL_DISABLE_CONTROL_ZERO_MSK;
    endfunction : legal_bits

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    reg_req_type req;
    logic [7:0]  ctrl_ff;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        hit;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    assign hit = (req.addr == PERIPHERAL_DISABLE_CONTROL_ZERO_OFS);

    // Write takes effect on the next edge; unused bits never store
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (req.wr && hit) begin
            nxt_ctrl = legal_bits(req.wdata);
        end
        nxt_rdata = 8'h00;
        if (req.rd && hit) begin
            nxt_rdata = legal_bits(ctrl_ff);
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_ff  <= PERIPHERAL_DISABLE_CONTROL_ZERO_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // Per-module gating
    // ----------------------------------------------------------------
    logic [NUM_MODULES-1:0] dis;
    gate_type               gate;

    // Map register bits onto module slots
    always_comb begin
        dis             = '0;
        dis[MOD_PERIPHERAL_SYSTEM_CLOCK] = ctrl_ff[SYSTEM_CLOCK_GATE_BIT];
        dis[MOD_VREF]   = ctrl_ff[VOLTAGE_REFERENCE_OFF_BIT];
        dis[MOD_NVM]    = ctrl_ff[NONVOLATILE_ACCESS_OFF_BIT];
        dis[MOD_CLKREF] = ctrl_ff[CLOCK_REFERENCE_OFF_BIT];
        dis[MOD_PINCHG] = ctrl_ff[PIN_CHANGE_DETECT_OFF_BIT];
    end

    // Wake delay per module; enable waits so software sees a settled unit
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_wake
        pmd_wake #(
            .CYCLES (WAKE)
        ) u_wake (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_i),
            .disable_i (dis[m]),
            .active_o  (gate.active[m])
        );
    end

    // Clock enable cut and reset held while the bit is set
    assign gate.clk_en   = ~dis;
    assign gate.hold_rst = dis;

    assign clk_en_o      = gate.clk_en;
    assign hold_rst_o    = gate.hold_rst;
    assign active_o      = gate.active;
    // Only the system clock network is cut here; other modules keep their clocks
    assign peripheral_system_clock_gate_o = dis[MOD_PERIPHERAL_SYSTEM_CLOCK];

    // ----------------------------------------------------------------
    // Register access fencing
    // ----------------------------------------------------------------
    logic [NUM_MODULES*8-1:0] per_rdata_ff;
    logic [NUM_MODULES*8-1:0] nxt_per_rdata;

    // Read data registered; a disabled module returns zero
    always_comb begin
        nxt_per_rdata = '0;
        for (int m = 0; m < NUM_MODULES; m++) begin
            if (per_rd_i[m] && !dis[m]) begin
                nxt_per_rdata[m*8 +: 8] = per_rdata_i[m*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            per_rdata_ff <= '0;
        end else begin
            per_rdata_ff <= nxt_per_rdata;
        end
    end

    assign per_rdata_o = per_rdata_ff;
    assign per_wr_o    = per_wr_i & ~dis;
    assign route_wr_o  = route_wr_i & ~dis;
    assign route_en_o  = ~dis;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Reset: control and both read-data registers come up clear
    reset_clear_a: assert property (@(posedge clk_i)
        !rst_n_i |=> ctrl_ff == 8'h00) else $error("control not cleared by reset");
    reset_rdata_a: assert property (@(posedge clk_i)
        !rst_n_i |=> rdata_o == 8'h00 && per_rdata_o == '0)
        else $error("read data not cleared by reset");

    // Gating follows the register from the write edge onward
    gate_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && hit |=> clk_en_o == ~hold_rst_o && hold_rst_o[MOD_CLKREF] == $past(wdata_i[1]))
        else $error("gating does not follow write");
    // A unit whose clock is cut must never report itself active
    active_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active_o & ~clk_en_o) == '0) else $error("disabled unit shows active");

    // Write strobes: fenced while disabled, passed while enabled
    write_fence_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_rst_o[MOD_NVM] |-> !per_wr_o[MOD_NVM]) else $error("write passed to disabled unit");
    wr_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        per_wr_i[MOD_CLKREF] && !hold_rst_o[MOD_CLKREF] |-> per_wr_o[MOD_CLKREF])
        else $error("write lost on enabled unit");

    // Reads: zero from a disabled unit, the unit's byte otherwise
    read_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        per_rd_i[MOD_VREF] && hold_rst_o[MOD_VREF] |=> per_rdata_o[15:8] == 8'h00)
        else $error("disabled unit read not zero");
    nvm_read_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        per_rd_i[MOD_NVM] && hold_rst_o[MOD_NVM] |=> per_rdata_o[23:16] == 8'h00)
        else $error("disabled memory read not zero");
    read_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        per_rd_i[MOD_PINCHG] && !hold_rst_o[MOD_PINCHG] |=> per_rdata_o[39:32] == $past(per_rdata_i[39:32]))
        else $error("enabled unit read lost");

    // Pin routing goes down together with its module
    route_fence_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hold_rst_o[MOD_PINCHG] |-> !route_wr_o[MOD_PINCHG] && !route_en_o[MOD_PINCHG])
        else $error("routing not disabled");
    route_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        route_en_o == clk_en_o) else $error("routing enable differs from clock enable");

    // System clock cut and clock reference bit
    peripheral_system_clock_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && hit && wdata_i[7] |=> peripheral_system_clock_gate_o) else $error("peripheral_system_clock not gated");
    peripheral_system_clock_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        peripheral_system_clock_gate_o == hold_rst_o[MOD_PERIPHERAL_SYSTEM_CLOCK]) else $error("peripheral_system_clock gate on wrong slot");
    clkref_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && hit |=> clk_en_o[MOD_CLKREF] == !$past(wdata_i[CLOCK_REFERENCE_OFF_BIT]))
        else $error("clock reference enable wrong");

    // Register port: masked storage, unmapped writes dropped, reads one cycle
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_i && hit |=> rdata_o[5:3] == 3'h0 && rdata_o == $past(ctrl_ff))
        else $error("read mismatch");
    ctrl_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ctrl_ff & ~PERIPHERAL_DISABLE_CONTROL_ZERO_MSK) == 8'h00) else $error("unused control bits stored");
    unmapped_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && !hit |=> ctrl_ff == $past(ctrl_ff)) else $error("unmapped write stored");
    rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(rd_i && hit) |=> rdata_o == 8'h00) else $error("read data outside read cycle");

    // Re-enable starts from reset, never instantly active
    reenable_rst_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(hold_rst_o[MOD_NVM]) |-> !active_o[MOD_NVM] ##1 !active_o[MOD_NVM])
        else $error("re-enable not from reset");

    // Main scenarios worth seeing at least once
    disable_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(hold_rst_o[MOD_CLKREF]));
    reenable_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(active_o[MOD_NVM]));
    fenced_rd_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) per_rd_i[MOD_VREF] && dis[MOD_VREF]);
    unmapped_wr_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_i && !hit);
    clkref_back_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(hold_rst_o[MOD_CLKREF]));

endmodule : peripheral_module_disable

/* tb/peripheral_module_disable_tb_top.sv */
/*
 * Self-checking bench for peripheral_module_disable: a reset test, a table of
 * control writes, then fencing, wake, unmapped-address and mid-run reset tests.
 * Assumes pmd_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
module peripheral_module_disable_tb_top;
    import pmd_pkg::*;
    logic        clk_i, rst_n_i, wr_i, rd_i, peripheral_system_clock_gate_o;
    logic [7:0]  addr_i, wdata_i, rdata_o, rd_val;
    logic [4:0]  per_wr_i, per_rd_i, per_wr_o, route_wr_i, route_wr_o;
    logic [4:0]  route_en_o, clk_en_o, hold_rst_o, active_o;
    logic [39:0] per_rdata_i, per_rdata_o;
    int          num_errors = 0;
    int          check_count = 0;
    // Last row leaves nonvolatile access and voltage reference off for the fencing test
    logic [7:0]  rows [8] = '{8'h00, 8'hFF, 8'h02, 8'h01, 8'h40, 8'h80, 8'h38, 8'h44};

    peripheral_module_disable #(.WAKE(WAKE_CYCLES)) uut (.clk_i, .rst_n_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .per_wr_i, .per_rd_i, .per_rdata_i, .per_wr_o, .per_rdata_o,
        .route_wr_i, .route_wr_o, .route_en_o, .clk_en_o, .hold_rst_o, .active_o, .peripheral_system_clock_gate_o);

    // ----------------------------------------
    // Clock, checks and bus tasks
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Slot order: 4 pin change, 3 clock ref, 2 nvm, 1 vref, 0 peripheral_system_clock
    function automatic logic [4:0] dis_of(input logic [7:0] v);
        return {v[0], v[1], v[2], v[6], v[7]};
    endfunction : dis_of

    task automatic chk_gate(input logic [7:0] v);
        chk(clk_en_o, 5'(~dis_of(v)), "clk_en");
        chk(hold_rst_o, dis_of(v), "hold_rst");
        chk(route_en_o, 5'(~dis_of(v)), "route_en");
        chk(peripheral_system_clock_gate_o, v[7], "peripheral_system_clock_gate");
    endtask : chk_gate

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : reg_rd

    // ----------------------------------------
    // Watchdog: whole run is about a hundred clocks
    // ----------------------------------------
    initial begin
        #(CLK_PERIOD_NS * 4000);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {wr_i, rd_i, addr_i, wdata_i, per_wr_i, per_rd_i, route_wr_i} = '0;
        per_rdata_i = '0;
        rst_n_i = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_gate(8'h00);
        chk(active_o, 5'h00, "active before wake");
        repeat (WAKE_CYCLES + 1) @(posedge clk_i);
        #1;
        chk(active_o, 5'h1F, "active after wake");
        $display("test reset done");
        // Table: write, gating outputs, read back through the mask
        foreach (rows[i]) begin
            reg_wr(8'h00, rows[i]);
            chk_gate(rows[i]);
            reg_rd(8'h00, rd_val);
            chk(rd_val, rows[i] & 8'hC7, "readback");
        end
        $display("test table done");
        // Nvm and vref slots off: strobes fenced, reads give zero
        @(posedge clk_i);
        per_wr_i <= 5'h1F;
        route_wr_i <= 5'h1F;
        per_rd_i <= 5'h1F;
        per_rdata_i <= 40'h5A4B3C2D1E;
        #1;
        chk(per_wr_o, 5'h19, "per_wr fence");
        chk(route_wr_o, 5'h19, "route_wr fence");
        chk(active_o[2:1], 2'b00, "disabled active");
        @(posedge clk_i);
        {per_wr_i, route_wr_i, per_rd_i} <= '0;
        #1;
        chk(per_rdata_o, 40'h5A4B00001E, "per_rdata");
        $display("test fence done");
        // Re-enable: reset released, active after the wake count
        reg_wr(8'h00, 8'h00);
        chk(hold_rst_o, 5'h00, "re-enable reset");
        chk(active_o[2], 1'b0, "wake not yet");
        repeat (WAKE_CYCLES + 1) @(posedge clk_i);
        #1;
        chk(active_o, 5'h1F, "wake done");
        // Memory data only touched once its settling time has passed
        repeat (1000 / CLK_PERIOD_NS) @(posedge clk_i);
        per_rd_i <= 5'h04;
        @(posedge clk_i);
        per_rd_i <= 5'h00;
        #1;
        chk(per_rdata_o, 40'h00003C0000, "nvm read after wake");
        $display("test wake done");
        // Unmapped address neither stores nor returns data
        reg_wr(8'h01, 8'hFF);
        chk_gate(8'h00);
        reg_rd(8'h01, rd_val);
        chk(rd_val, 8'h00, "unmapped read");
        $display("test unmapped done");
        // Reset in mid-run clears every disable bit
        reg_wr(8'h00, 8'hFF);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_gate(8'h00);
        chk(active_o, 5'h00, "active after midrun reset");
        reg_rd(8'h00, rd_val);
        chk(rd_val, 8'h00, "reset readback");
        $display("test midrun reset done");
        end_sim();
    end
endmodule : peripheral_module_disable_tb_top
